// ---- hw/swd_watchdog.sv ----
// Purpose: Watchdog control and interrupt enables behind AXI4-Lite
// Assumes: Single-beat AXI4-Lite master, one write and one read at a time
// Notes:   Internal reset clears this block except the expired flag and the interrupt status and mask
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module swd_watchdog
    import swd_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
)
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    input  wire logic [NUM_SRC-1:0]  src_req,
    output logic [NUM_SRC-1:0]       src_deliver,
    output logic                     wd_reset_req,
    output logic                     irq
);

    if (ADDR_W < 10)
    begin : g_chk
        $error("ADDR_W must be at least 10");
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode: true when a byte address hits the given register index
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        logic [ADDR_W-1:0] full;
        full = ADDR_W'({idx, 2'b00});
        return (a[ADDR_W-1:2] == full[ADDR_W-1:2]);
    endfunction

    swd_cnt_if cif ();

    swd_counter u_counter
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cif     (cif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake state
    logic        awready_q, awready_d;
    logic        bvalid_q,  bvalid_d;
    logic [1:0]  bresp_q,   bresp_d;
    logic        arready_q, arready_d;
    logic        rvalid_q,  rvalid_d;
    logic [1:0]  rresp_q,   rresp_d;
    logic [31:0] rdata_q,   rdata_d;
    logic        do_wr;
    logic        do_rd;
    logic        wr_ok;
    logic        wr_low;
    logic        wr_high;
    logic        wr_prio;
    logic        wr_rel;
    logic        wr_sts;
    logic        wr_msk;

    // Register state
    logic [7:0]  ien_low_q,  ien_low_d;
    logic [7:0]  ien_high_q, ien_high_d;
    logic [7:0]  prio_q,     prio_d;
    logic [7:0]  reload_q,   reload_d;
    logic        arm_q,      arm_d;
    logic [3:0]  arm_cnt_q,  arm_cnt_d;
    logic        start_q,    start_d;
    logic [3:0]  start_cnt_q, start_cnt_d;
    logic        exp_q,      exp_d;
    logic        wd_rst_q;
    logic [NUM_EV-1:0] sts_q, sts_d;
    logic [NUM_EV-1:0] msk_q, msk_d;
    logic        irq_q;
    logic [NUM_SRC-1:0] deliver_q;
    logic [NUM_SRC-1:0] src_en;
    logic        arm_wr;
    logic        start_wr;
    logic        refresh;
    logic        lapse;
    logic [NUM_EV-1:0]  ev;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: address and data are taken together
    always_comb
    begin
        do_wr     = awready_q && awvalid && wvalid;
        awready_d = awvalid && wvalid && !awready_q && !bvalid_q;
        wr_ok     = hit(awaddr, IDX_IEN_LOW)  || hit(awaddr, IDX_IEN_HIGH)
                 || hit(awaddr, IDX_PRIO)     || hit(awaddr, IDX_RELOAD)
                 || hit(awaddr, IDX_IRQ_STS)  || hit(awaddr, IDX_IRQ_MSK);
        bvalid_d  = do_wr || (bvalid_q && !bready);
        bresp_d   = do_wr ? (wr_ok ? RESP_OKAY : RESP_SLVERR) : bresp_q;
        // Only byte lane 0 carries register data
        wr_low    = do_wr && wstrb[0] && hit(awaddr, IDX_IEN_LOW);
        wr_high   = do_wr && wstrb[0] && hit(awaddr, IDX_IEN_HIGH);
        wr_prio   = do_wr && wstrb[0] && hit(awaddr, IDX_PRIO);
        wr_rel    = do_wr && wstrb[0] && hit(awaddr, IDX_RELOAD);
        wr_sts    = do_wr && wstrb[0] && hit(awaddr, IDX_IRQ_STS);
        wr_msk    = do_wr && wstrb[0] && hit(awaddr, IDX_IRQ_MSK);

        do_rd     = arready_q && arvalid;
        arready_d = arvalid && !arready_q && !rvalid_q;
        rvalid_d  = do_rd || (rvalid_q && !rready);
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (do_rd)
        begin
            rresp_d = RESP_OKAY;
            if (hit(araddr, IDX_IEN_LOW))
                rdata_d = {24'h000000, ien_low_q[7], arm_q, ien_low_q[5:0]};
            else if (hit(araddr, IDX_IEN_HIGH))
                rdata_d = {24'h000000, 1'b0, start_q, ien_high_q[5:0]};
            else if (hit(araddr, IDX_PRIO))
                rdata_d = {24'h000000, 1'b0, exp_q, prio_q[5:0]};
            else if (hit(araddr, IDX_RELOAD))
                rdata_d = {24'h000000, reload_q};
            else if (hit(araddr, IDX_IRQ_STS))
                rdata_d = {29'h00000000, sts_q};
            else if (hit(araddr, IDX_IRQ_MSK))
                rdata_d = {29'h00000000, msk_q};
            else
            begin
                rdata_d = 32'h00000000;
                rresp_d = RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog control and enables
    always_comb
    begin
        arm_wr   = wr_low && wdata[BIT_ARM];
        start_wr = wr_high && wdata[BIT_START];
        refresh  = start_wr && arm_q && !wd_rst_q;
        lapse    = arm_q && !refresh && !arm_wr
                && arm_cnt_q == FLAG_HOLD_CYC - 4'h1;

        ien_low_d  = wr_low  ? (wdata[7:0] & IEN_LOW_MASK)  : ien_low_q;
        ien_high_d = wr_high ? (wdata[7:0] & IEN_HIGH_MASK) : ien_high_q;
        prio_d     = wr_prio ? (wdata[7:0] & PRIO_MASK)     : prio_q;
        reload_d   = wr_rel  ? wdata[7:0]                   : reload_q;

        // Arm window: a refresh consumes it, otherwise it lapses
        arm_d     = arm_q;
        arm_cnt_d = arm_cnt_q;
        if (arm_wr)
        begin
            arm_d     = 1'b1;
            arm_cnt_d = 4'h0;
        end
        else if (refresh || lapse)
        begin
            arm_d     = 1'b0;
            arm_cnt_d = 4'h0;
        end
        else if (arm_q)
        begin
            arm_cnt_d = arm_cnt_q + 4'h1;
        end

        start_d     = start_q;
        start_cnt_d = start_cnt_q;
        if (start_wr)
        begin
            start_d     = 1'b1;
            start_cnt_d = 4'h0;
        end
        else if (start_q && start_cnt_q == FLAG_HOLD_CYC - 4'h1)
        begin
            start_d     = 1'b0;
            start_cnt_d = 4'h0;
        end
        else if (start_q)
        begin
            start_cnt_d = start_cnt_q + 4'h1;
        end

        // Hardware set wins over a software clear
        exp_d = cif.expire
             || (exp_q && !(wr_prio && !wdata[BIT_EXPIRED]));

        // Internal reset clears enables, priority, reload, arm and start; expired flag, status and mask are kept
        if (wd_rst_q)
        begin
            ien_low_d   = RST_REG8;
            ien_high_d  = RST_REG8;
            prio_d      = RST_REG8;
            reload_d    = RST_REG8;
            arm_d       = 1'b0;
            arm_cnt_d   = 4'h0;
            start_d     = 1'b0;
            start_cnt_d = 4'h0;
        end

        ev              = '0;
        ev[EV_EXPIRE]   = cif.expire;
        ev[EV_REFRESH]  = refresh;
        ev[EV_LAPSE]    = lapse && !wd_rst_q;
        sts_d = (sts_q & ~(wr_sts ? wdata[NUM_EV-1:0] : '0)) | ev;
        msk_d = wr_msk ? wdata[NUM_EV-1:0] : msk_q;

        src_en = {1'b0, ien_high_q[5:1], ien_low_q[4:0]}
               & {NUM_SRC{ien_low_q[BIT_GLOBAL_EN]}};
    end

    assign cif.start   = start_wr && !wd_rst_q;
    assign cif.refresh = refresh;
    assign cif.stop    = wd_rst_q;
    assign cif.psel    = reload_q[BIT_PSEL];
    assign cif.reload  = reload_q[6:0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q   <= 1'b0;
            bvalid_q    <= 1'b0;
            bresp_q     <= RESP_OKAY;
            arready_q   <= 1'b0;
            rvalid_q    <= 1'b0;
            rresp_q     <= RESP_OKAY;
            rdata_q     <= 32'h00000000;
            ien_low_q   <= RST_REG8;
            ien_high_q  <= RST_REG8;
            prio_q      <= RST_REG8;
            reload_q    <= RST_REG8;
            arm_q       <= 1'b0;
            arm_cnt_q   <= 4'h0;
            start_q     <= 1'b0;
            start_cnt_q <= 4'h0;
            exp_q       <= 1'b0;
            wd_rst_q    <= 1'b0;
            sts_q       <= '0;
            msk_q       <= '0;
            irq_q       <= 1'b0;
            deliver_q   <= '0;
        end
        else
        begin
            awready_q   <= awready_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            arready_q   <= arready_d;
            rvalid_q    <= rvalid_d;
            rresp_q     <= rresp_d;
            rdata_q     <= rdata_d;
            ien_low_q   <= ien_low_d;
            ien_high_q  <= ien_high_d;
            prio_q      <= prio_d;
            reload_q    <= reload_d;
            arm_q       <= arm_d;
            arm_cnt_q   <= arm_cnt_d;
            start_q     <= start_d;
            start_cnt_q <= start_cnt_d;
            exp_q       <= exp_d;
            wd_rst_q    <= cif.expire;
            sts_q       <= sts_d;
            msk_q       <= msk_d;
            irq_q       <= |(sts_d & msk_d);
            deliver_q   <= src_req & src_en;
        end
    end

    assign awready      = awready_q;
    assign wready       = awready_q;
    assign bvalid       = bvalid_q;
    assign bresp        = bresp_q;
    assign arready      = arready_q;
    assign rvalid       = rvalid_q;
    assign rresp        = rresp_q;
    assign rdata        = rdata_q;
    assign src_deliver  = deliver_q;
    assign wd_reset_req = wd_rst_q;
    assign irq          = irq_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_armed_start;
        arm_q && start_wr && !wd_rst_q;
    endsequence

    sequence s_expiry;
        cif.expire;
    endsequence

    a_global_gate: assert property (
        !ien_low_q[BIT_GLOBAL_EN] |=> src_deliver == '0)
        else $error("source delivered with global enable off");

    a_source_gate: assert property (
        1'b1 |=> (src_deliver & ~$past(src_en)) == '0)
        else $error("disabled source was delivered");

    a_arm_lapse: assert property (
        arm_q && arm_cnt_q == 4'hB && !arm_wr && !wd_rst_q |=> !arm_q)
        else $error("arm bit not cleared after 12 cycles");

    a_arm_holds: assert property (
        arm_q && arm_cnt_q < 4'hB && !refresh && !wd_rst_q |=> arm_q)
        else $error("arm bit cleared too early");

    a_armed_refresh: assert property (
        s_armed_start |=> cif.count == {1'b0, $past(reload_q[6:0]), 8'h00})
        else $error("refresh did not load reload value");

    a_start_clear: assert property (
        start_q && start_cnt_q == 4'hB && !start_wr && !wd_rst_q
        |=> !start_q)
        else $error("start bit not cleared after 12 cycles");

    a_expire_reset: assert property (
        s_expiry |=> wd_reset_req && exp_q ##1 !wd_reset_req && exp_q)
        else $error("expiry did not raise flag and internal reset");

    a_flag_survives: assert property (
        wd_rst_q |=> exp_q)
        else $error("expired flag lost through internal reset");

    a_lapse_no_load: assert property (
        lapse && !wd_rst_q |-> !cif.refresh ##1 !arm_q && sts_q[EV_LAPSE])
        else $error("lapsed arm window reloaded the counter");

endmodule

// ---- hw/swd_pkg.sv ----
// Purpose: Shared constants and types of the software watchdog block
// Assumes: 40 MHz core clock, AXI4-Lite register access
// Notes:   Register offsets are indices; byte address is index times four
package swd_pkg;

    localparam int unsigned CLK_HZ        = 40_000_000;

    // Register indices
    localparam logic [7:0]  IDX_RELOAD    = 8'h86;
    localparam logic [7:0]  IDX_PRIO      = 8'hA9;
    localparam logic [7:0]  IDX_IEN_LOW   = 8'hA8;
    localparam logic [7:0]  IDX_IEN_HIGH  = 8'hB8;
    localparam logic [7:0]  IDX_IRQ_STS   = 8'hC0;
    localparam logic [7:0]  IDX_IRQ_MSK   = 8'hC1;

    // Field positions
    localparam int unsigned BIT_GLOBAL_EN = 7;
    localparam int unsigned BIT_ARM       = 6;
    localparam int unsigned BIT_START     = 6;
    localparam int unsigned BIT_EXPIRED   = 6;
    localparam int unsigned BIT_PSEL      = 7;

    // Writable bits of each register
    localparam logic [7:0]  IEN_LOW_MASK  = 8'h9F;
    localparam logic [7:0]  IEN_HIGH_MASK = 8'h3E;
    localparam logic [7:0]  PRIO_MASK     = 8'h3F;

    // Reset values
    localparam logic [7:0]  RST_REG8      = 8'h00;
    localparam logic [15:0] RST_COUNT     = 16'h0000;

    // Timing counts in core clock cycles; expiry value in counter ticks
    localparam logic [3:0]  FLAG_HOLD_CYC = 4'hC;
    localparam logic [8:0]  TICK_FAST_CYC = 9'h018;
    localparam logic [8:0]  TICK_SLOW_CYC = 9'h180;
    localparam logic [15:0] WD_EXPIRE_CNT = 16'h7CFF;

    // Interrupt event bits
    localparam int unsigned EV_EXPIRE     = 0;
    localparam int unsigned EV_REFRESH    = 1;
    localparam int unsigned EV_LAPSE      = 2;
    localparam int unsigned NUM_EV        = 3;

    localparam int unsigned NUM_SRC       = 11;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [0:0]
    {
        SWD_IDLE = 1'b0,
        SWD_RUN  = 1'b1
    } swd_state_e;

endpackage

// ---- hw/swd_cnt_if.sv ----
// Purpose: Carrier between the watchdog control and its counter
// Assumes: One clock domain
// Notes:   Start, refresh and stop are one-cycle pulses
`timescale 1ns/100ps
interface swd_cnt_if;
    logic        start;
    logic        refresh;
    logic        stop;
    logic        psel;
    logic [6:0]  reload;
    logic        running;
    logic        expire;
    logic [15:0] count;

    modport ctl (output start, refresh, stop, psel, reload,
                 input  running, expire, count);
    modport cnt (input  start, refresh, stop, psel, reload,
                 output running, expire, count);
endinterface

// ---- hw/swd_counter.sv ----
// Purpose: 16-bit watchdog counter with its prescaler
// Assumes: Control pulses come from the register side
// Notes:   Only stop halts a running counter
`timescale 1ns/100ps
module swd_counter
    import swd_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    swd_cnt_if.cnt    cif
);

    swd_state_e  state_q;
    swd_state_e  state_d;
    logic [8:0]  pre_q;
    logic [8:0]  pre_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        exp_q;
    logic        exp_d;
    logic [8:0]  lim;

    always_comb
    begin
        lim     = cif.psel ? TICK_SLOW_CYC - 9'h001
                           : TICK_FAST_CYC - 9'h001;
        state_d = state_q;
        pre_d   = pre_q;
        cnt_d   = cnt_q;
        if (cif.stop)
        begin
            state_d = SWD_IDLE;
            pre_d   = 9'h000;
            cnt_d   = RST_COUNT;
        end
        else if (cif.refresh)
        begin
            state_d = SWD_RUN;
            pre_d   = 9'h000;
            cnt_d   = {1'b0, cif.reload, 8'h00};
        end
        else
        begin
            if (cif.start)
            begin
                state_d = SWD_RUN;
            end
            case (state_q)
                SWD_RUN:
                begin
                    // Psel may drop mid-count, so compare with >=
                    if (pre_q >= lim)
                    begin
                        pre_d = 9'h000;
                        cnt_d = cnt_q + 16'h0001;
                    end
                    else
                    begin
                        pre_d = pre_q + 9'h001;
                    end
                end
                default:
                begin
                    pre_d = pre_q;
                end
            endcase
        end
        exp_d = (cnt_d == WD_EXPIRE_CNT) && (cnt_q != WD_EXPIRE_CNT)
                && !cif.stop;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= SWD_IDLE;
            pre_q   <= 9'h000;
            cnt_q   <= RST_COUNT;
            exp_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            pre_q   <= pre_d;
            cnt_q   <= cnt_d;
            exp_q   <= exp_d;
        end
    end

    assign cif.running = (state_q == SWD_RUN);
    assign cif.expire  = exp_q;
    assign cif.count   = cnt_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_run_holds: assert property (
        cif.running && !cif.stop |=> cif.running)
        else $error("watchdog stopped without internal reset");

    a_prescale_hold: assert property (
        cif.running && !cif.stop && !cif.refresh && pre_q < lim
        |=> cnt_q == $past(cnt_q))
        else $error("counter advanced before prescaler ran out");

endmodule

// ---- verification/tb.sv ----
// Purpose: Self-checking bench of the software watchdog block
// Assumes: AXI4-Lite master driven here; register map as in swd_pkg
// Notes:   Expiry is reached with reload 0x7C, so about 6k cycles a run
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import swd_pkg::*;

    logic              aclk        = 1'b0;
    logic              aresetn     = 1'b0;
    logic [11:0]       awaddr      = '0;
    logic              awvalid     = 1'b0;
    logic              awready;
    logic [31:0]       wdata       = '0;
    logic [3:0]        wstrb       = '0;
    logic              wvalid      = 1'b0;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready      = 1'b0;
    logic [11:0]       araddr      = '0;
    logic              arvalid     = 1'b0;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready      = 1'b0;
    logic [NUM_SRC-1:0] src_req    = '0;
    logic [NUM_SRC-1:0] src_deliver;
    logic              wd_reset_req;
    logic              irq;
    int                n_fail      = 0;
    int                checks_done = 0;
    logic [31:0]       rd;
    logic [1:0]        rsp;
    logic [7:0]        lo;
    logic [7:0]        hi;
    int                cnt;
    logic [7:0]        all_idx [6] = '{IDX_RELOAD, IDX_PRIO, IDX_IEN_LOW,
                                       IDX_IEN_HIGH, IDX_IRQ_STS,
                                       IDX_IRQ_MSK};

    always #12.5 aclk = ~aclk;

    swd_watchdog #(.ADDR_W(12)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .src_req(src_req), .src_deliver(src_deliver),
        .wd_reset_req(wd_reset_req), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] adr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    function automatic logic [9:0] exp_del(input logic [7:0] l,
        input logic [7:0] h, input logic [NUM_SRC-1:0] s);
        return {h[5:1], l[4:0]} & s[9:0] & {10{l[BIT_GLOBAL_EN]}};
    endfunction

    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
        input logic [3:0] sb, output logic [1:0] r);
        int k;
        k = 0;
        @(posedge aclk);
        awaddr  <= adr(idx);
        wdata   <= {24'h000000, d};
        wstrb   <= sb;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid && k < 100);
        if (!bvalid) n_fail++;
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] idx, output logic [31:0] d,
        output logic [1:0] r);
        int k;
        k = 0;
        @(posedge aclk);
        araddr  <= adr(idx);
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid && k < 100);
        if (!rvalid) n_fail++;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr_ok(input logic [7:0] idx, input logic [7:0] d);
        logic [1:0] r;
        wr(idx, d, 4'hF, r);
        `CHK(r, RESP_OKAY)
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rdr(idx, d, r);
        `CHK(r, RESP_OKAY)
        `CHK(d, {24'h000000, e})
    endtask

    task automatic wrap_up;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Longest path is two timeouts of about 6.5k cycles each
    initial
    begin
        repeat (60000) @(posedge aclk);
        n_fail++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(87801));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (all_idx[i])
            rd_chk(all_idx[i], 8'h00);
        rdr(8'h10, rd, rsp);
        `CHK(rsp, RESP_SLVERR)
        `CHK(rd, 32'h00000000)
        wr(8'h10, 8'hFF, 4'hF, rsp);
        `CHK(rsp, RESP_SLVERR)
        wr(IDX_IEN_LOW, 8'h9F, 4'h0, rsp);
        `CHK(rsp, RESP_OKAY)
        rd_chk(IDX_IEN_LOW, 8'h00);
        // Corners first: global off with all sources on, then global on
        for (int n = 0; n < 12; n++)
        begin
            lo = (n == 0) ? 8'h1F : (n == 1) ? 8'h9F : 8'($urandom) & 8'h9F;
            hi = (n < 2) ? 8'h3E : 8'($urandom) & 8'h3E;
            wr_ok(IDX_IEN_LOW, lo);
            wr_ok(IDX_IEN_HIGH, hi);
            rd_chk(IDX_IEN_LOW, lo);
            rd_chk(IDX_IEN_HIGH, hi);
            for (int m = 0; m < 3; m++)
            begin
                @(posedge aclk);
                src_req <= (m == 0) ? '1 : NUM_SRC'($urandom);
                repeat (2) @(posedge aclk);
                #1;
                `CHK(src_deliver[9:0], exp_del(lo, hi, src_req))
                `CHK(src_deliver[10], 1'b0)
            end
        end
        wr_ok(IDX_IEN_LOW, 8'h00);
        wr_ok(IDX_PRIO, 8'h7F);
        rd_chk(IDX_PRIO, 8'h3F);
        // Arm lapse with the event masked, then unmasked
        for (int m = 0; m < 2; m++)
        begin
            wr_ok(IDX_IRQ_MSK, m ? 8'h07 : 8'h03);
            wr_ok(IDX_IEN_LOW, 8'h40);
            rd_chk(IDX_IEN_LOW, 8'h40);
            repeat (14) @(posedge aclk);
            rd_chk(IDX_IEN_LOW, 8'h00);
            rd_chk(IDX_IRQ_STS, 8'h04);
            #1;
            `CHK(irq, (m == 1))
            wr_ok(IDX_IRQ_STS, 8'h04);
            repeat (2) @(posedge aclk);
            #1;
            `CHK(irq, 1'b0)
        end
        // Slow prescaler: would expire near 6.1k cycles if divide were lost
        wr_ok(IDX_RELOAD, 8'hFC);
        wr_ok(IDX_IEN_LOW, 8'h40);
        wr_ok(IDX_IEN_HIGH, 8'h40);
        rd_chk(IDX_IEN_HIGH, 8'h40);
        rd_chk(IDX_IEN_LOW, 8'h00);
        rd_chk(IDX_IRQ_STS, 8'h02);
        #1;
        `CHK(irq, 1'b1)
        wr_ok(IDX_IRQ_STS, 8'h02);
        rd_chk(IDX_IEN_HIGH, 8'h00);
        cnt = 0;
        repeat (6500) @(posedge aclk) cnt += wd_reset_req;
        `CHK(cnt, 0)
        // Refresh again on the fast prescaler; low byte must restart at 0
        wr_ok(IDX_RELOAD, 8'h7C);
        wr_ok(IDX_IEN_LOW, 8'h40);
        wr_ok(IDX_IEN_HIGH, 8'h40);
        cnt = 0;
        do
        begin
            @(posedge aclk);
            cnt++;
        end
        while (!wd_reset_req && cnt < 6400);
        `CHK(cnt >= 255 * 24 - 30 && cnt <= 255 * 24 + 30, 1'b1)
        rd_chk(IDX_PRIO, 8'h40);
        rd_chk(IDX_RELOAD, 8'h00);
        // Refresh event of the second refresh is still pending
        rd_chk(IDX_IRQ_STS, 8'h03);
        wr_ok(IDX_PRIO, 8'h00);
        rd_chk(IDX_PRIO, 8'h00);
        wr_ok(IDX_IRQ_STS, 8'h07);
        wrap_up();
    end
endmodule
